/* File: prog_port_pkg.sv */
// Constants, states and carriers of the parallel programming port.
// Assumes one 100 MHz system clock and a slow load strobe clock from the programmer.
`default_nettype none
package prog_port_pkg;
  // Memory geometry defaults
  localparam int FLASH_AW_DEF = 10;
  localparam int PAGE_AW_DEF = 4;
  localparam int EE_AW_DEF = 7;
  localparam int EE_PAGE_AW_DEF = 2;
  // Load actions chosen by the two action-select pins
  localparam logic [1:0] ACT_ADDR = 2'h0;
  localparam logic [1:0] ACT_DATA = 2'h1;
  localparam logic [1:0] ACT_CMD = 2'h2;
  localparam logic [1:0] ACT_IDLE = 2'h3;
  // Command bytes
  localparam logic [7:0] CMD_ERASE = 8'h80;
  localparam logic [7:0] CMD_WR_FUSE = 8'h40;
  localparam logic [7:0] CMD_WR_LOCK = 8'h20;
  localparam logic [7:0] CMD_WR_FLASH = 8'h10;
  localparam logic [7:0] CMD_WR_EE = 8'h11;
  localparam logic [7:0] CMD_RD_SIG = 8'h08;
  localparam logic [7:0] CMD_RD_FUSE = 8'h04;
  localparam logic [7:0] CMD_RD_FLASH = 8'h02;
  localparam logic [7:0] CMD_RD_EE = 8'h03;
  // Values after reset and after erase
  localparam logic [7:0] CMD_RESET = 8'h00;
  localparam logic [7:0] FUSE_LOW_RESET = 8'hFF;
  localparam logic [7:0] FUSE_HIGH_RESET = 8'hFF;
  localparam logic [7:0] FUSE_EXT_RESET = 8'hFF;
  localparam logic [7:0] LOCK_RESET = 8'hFF;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;
  // Preserve-EEPROM fuse position in the high fuse byte, programmed when 0
  localparam int EE_PRESERVE_BIT = 6;
  // Cycles after reset release before the entry pattern is sampled
  localparam logic [1:0] ENTRY_SETTLE = 2'h3;
  // Identity bytes: arbitrary values
  localparam logic [7:0] SIG_BYTE0 = 8'h5A;
  localparam logic [7:0] SIG_BYTE1 = 8'h3C;
  localparam logic [7:0] SIG_BYTE2 = 8'h42;
  localparam logic [7:0] CAL_BYTE = 8'h80;
  // Synchroniser reset value of the control pins (strobes idle high)
  localparam logic [5:0] PIN_CTRL_RESET = 6'h30;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ERASE_FLASH = 3'h1,
    ST_ERASE_EE = 3'h3,
    ST_ERASE_LOCK = 3'h2,
    ST_PROG_FLASH = 3'h6,
    ST_PROG_EE = 3'h7,
    ST_WRITE_NV = 3'h4
  } prog_state_t;

  typedef struct packed {
    logic [1:0] action;
    logic half;
    logic [7:0] data;
  } load_event_t;

  typedef struct packed {
    logic wr_n;
    logic oe_n;
    logic sel1;
    logic sel0;
    logic half;
    logic ext;
  } pin_ctrl_t;
endpackage
`default_nettype wire

/* File: sync2.sv */
// Two flip-flop synchroniser for levels and toggles.
// Assumes the input is stable long enough to be seen; first stage feeds only the second.
`timescale 1ns/1ns
`default_nettype none
module sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and synchronous reset
  input wire logic clk,
  input wire logic reset_n,
  // Data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      meta <= RESET_VAL;
      q <= RESET_VAL;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // sync2
`default_nettype wire

/* File: parallel_program_port.sv */
// Parallel programming port: load path on the programmer's strobe clock, engine on clk_sys.
// Assumes the programmer keeps pin setup around each strobe and respects the busy flag.
`timescale 1ns/1ns
`default_nettype none
module parallel_program_port
  import prog_port_pkg::*;
#(
  parameter int FLASH_AW = FLASH_AW_DEF,
  parameter int PAGE_AW = PAGE_AW_DEF,
  parameter int EE_AW = EE_AW_DEF,
  parameter int EE_PAGE_AW = EE_PAGE_AW_DEF
) (
  // System clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Programmer load strobe, clock of the load path
  input wire logic load_strobe_clock,
  // Programmer control pins
  input wire logic load_action_sel0,
  input wire logic load_action_sel1,
  input wire logic byte_half_select,
  input wire logic byte_extended_select,
  input wire logic write_strobe_n,
  input wire logic read_enable_n,
  // Bidirectional data bus
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_n,
  // Status
  output logic prog_ready_flag,
  output logic prog_mode_active
);
  localparam int IDX_W = FLASH_AW;
  localparam logic [IDX_W-1:0] FLASH_LAST = '1;
  localparam logic [IDX_W-1:0] EE_LAST = IDX_W'((1 << EE_AW) - 1);
  localparam logic [IDX_W-1:0] PAGE_LAST = IDX_W'((1 << PAGE_AW) - 1);
  localparam logic [IDX_W-1:0] EE_PAGE_LAST = IDX_W'((1 << EE_PAGE_AW) - 1);

  // Load path on the strobe clock
  logic link_reset_n;
  load_event_t link_ev, next_link_ev;
  logic link_toggle, next_link_toggle;

  // The load clock only runs while the programmer strobes, so its reset is caught there
  sync2 #(.WIDTH(1), .RESET_VAL(1'b0)) u_link_reset (
    .clk(load_strobe_clock),
    .reset_n(1'b1),
    .d(reset_n),
    .q(link_reset_n)
  );

  always_comb begin
    next_link_ev = link_ev;
    next_link_toggle = link_toggle;
    if ({load_action_sel1, load_action_sel0} != ACT_IDLE) begin
      next_link_ev = '{action: {load_action_sel1, load_action_sel0}, half: byte_half_select, data: data_in};
      next_link_toggle = ~link_toggle;
    end
  end

  always_ff @(posedge load_strobe_clock) begin
    if (!link_reset_n) begin
      link_ev <= '0;
      link_toggle <= 1'b0;
    end else begin
      link_ev <= next_link_ev;
      link_toggle <= next_link_toggle;
    end
  end

  // Crossings into the system domain
  pin_ctrl_t pins;
  logic ev_toggle_s;

  sync2 #(.WIDTH(6), .RESET_VAL(PIN_CTRL_RESET)) u_pin_sync (
    .clk(clk_sys),
    .reset_n(reset_n),
    .d({write_strobe_n, read_enable_n, load_action_sel1, load_action_sel0, byte_half_select, byte_extended_select}),
    .q(pins)
  );

  sync2 #(.WIDTH(1), .RESET_VAL(1'b0)) u_ev_sync (
    .clk(clk_sys),
    .reset_n(reset_n),
    .d(link_toggle),
    .q(ev_toggle_s)
  );

  // System state
  prog_state_t state, next_state;
  logic [IDX_W-1:0] idx, next_idx;
  logic [7:0] cmd, next_cmd;
  logic [7:0] addr_lo, next_addr_lo, addr_hi, next_addr_hi, data_lo, next_data_lo;
  logic [7:0] fuse_low, next_fuse_low, fuse_high, next_fuse_high, fuse_ext, next_fuse_ext;
  logic [7:0] lock, next_lock;
  logic [1:0] settle, next_settle;
  logic next_mode, next_ready, ev_seen, wr_prev, next_oe_n;
  logic [7:0] next_data_out, rd_byte;
  logic [15:0] rd_word;

  // Memories and write ports
  logic [15:0] flash_mem [1 << FLASH_AW];
  logic [7:0] ee_mem [1 << EE_AW];
  logic [15:0] pbuf [1 << PAGE_AW];
  logic [7:0] eebuf [1 << EE_PAGE_AW];
  logic flash_we, ee_we, pbuf_we, eebuf_we;
  logic [FLASH_AW-1:0] flash_wa;
  logic [EE_AW-1:0] ee_wa;
  logic [15:0] flash_wd;
  logic [7:0] ee_wd;

  wire logic ev_fire = ev_toggle_s ^ ev_seen;
  wire load_event_t ev = link_ev;
  wire logic wr_fall = wr_prev & ~pins.wr_n;
  wire logic wr_go = wr_fall & prog_mode_active & (state == ST_IDLE);
  wire logic [FLASH_AW-1:0] flash_addr = FLASH_AW'({addr_hi, addr_lo});
  wire logic [EE_AW-1:0] ee_addr = EE_AW'({addr_hi, addr_lo});
  // Programmed fuse reads as 0
  wire logic eeprom_preserve_fuse = ~fuse_high[EE_PRESERVE_BIT];

  always_comb begin
    next_settle = settle;
    next_mode = prog_mode_active;
    if (settle != ENTRY_SETTLE) begin
      next_settle = settle + 2'h1;
      // Entry pattern is taken once, after the synchronisers hold real pin levels
      if (next_settle == ENTRY_SETTLE) begin
        next_mode = ~(pins.sel1 | pins.sel0 | pins.half | pins.wr_n);
      end
    end
  end

  always_comb begin
    next_state = state;
    next_idx = idx;
    next_cmd = cmd;
    next_addr_lo = addr_lo;
    next_addr_hi = addr_hi;
    next_data_lo = data_lo;
    next_fuse_low = fuse_low;
    next_fuse_high = fuse_high;
    next_fuse_ext = fuse_ext;
    next_lock = lock;
    flash_we = 1'b0;
    flash_wa = '0;
    flash_wd = ERASED_WORD;
    ee_we = 1'b0;
    ee_wa = '0;
    ee_wd = ERASED_BYTE;
    pbuf_we = 1'b0;
    eebuf_we = 1'b0;
    // Loads while busy are dropped so the running operation keeps its inputs
    if (ev_fire && prog_mode_active && prog_ready_flag) begin
      case (ev.action)
        ACT_ADDR: begin
          if (ev.half) begin
            next_addr_hi = ev.data;
          end else begin
            next_addr_lo = ev.data;
          end
        end
        ACT_DATA: begin
          if (ev.half) begin
            pbuf_we = (cmd == CMD_WR_FLASH);
          end else begin
            next_data_lo = ev.data;
            eebuf_we = (cmd == CMD_WR_EE);
          end
        end
        ACT_CMD: next_cmd = ev.data;
        default: ;
      endcase
    end
    case (state)
      ST_IDLE: begin
        if (wr_go) begin
          next_idx = '0;
          case (cmd)
            CMD_ERASE: next_state = ST_ERASE_FLASH;
            CMD_WR_FLASH: next_state = ST_PROG_FLASH;
            CMD_WR_EE: next_state = ST_PROG_EE;
            CMD_WR_FUSE, CMD_WR_LOCK: next_state = ST_WRITE_NV;
            default: ;
          endcase
        end
      end
      ST_ERASE_FLASH: begin
        flash_we = 1'b1;
        flash_wa = idx;
        next_idx = idx + 1'b1;
        if (idx == FLASH_LAST) begin
          next_idx = '0;
          next_state = eeprom_preserve_fuse ? ST_ERASE_LOCK : ST_ERASE_EE;
        end
      end
      ST_ERASE_EE: begin
        ee_we = 1'b1;
        ee_wa = ee_addr_of(idx);
        next_idx = idx + 1'b1;
        if (idx == EE_LAST) begin
          next_state = ST_ERASE_LOCK;
        end
      end
      ST_ERASE_LOCK: begin
        next_lock = LOCK_RESET;
        next_state = ST_IDLE;
      end
      ST_PROG_FLASH: begin
        flash_we = 1'b1;
        flash_wa = {flash_addr[FLASH_AW-1:PAGE_AW], idx[PAGE_AW-1:0]};
        flash_wd = pbuf[idx[PAGE_AW-1:0]];
        next_idx = idx + 1'b1;
        if (idx == PAGE_LAST) begin
          next_state = ST_IDLE;
        end
      end
      ST_PROG_EE: begin
        ee_we = 1'b1;
        ee_wa = {ee_addr[EE_AW-1:EE_PAGE_AW], idx[EE_PAGE_AW-1:0]};
        ee_wd = eebuf[idx[EE_PAGE_AW-1:0]];
        next_idx = idx + 1'b1;
        if (idx == EE_PAGE_LAST) begin
          next_state = ST_IDLE;
        end
      end
      ST_WRITE_NV: begin
        if (cmd == CMD_WR_LOCK) begin
          // Lock bits only program here; only erase or reset sets them back
          next_lock = lock & data_lo;
        end else begin
          case ({pins.ext, pins.half})
            2'h0: next_fuse_low = data_lo;
            2'h1: next_fuse_high = data_lo;
            default: next_fuse_ext = data_lo;
          endcase
        end
        next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
    next_ready = (next_state == ST_IDLE);
  end

  function automatic logic [EE_AW-1:0] ee_addr_of(input logic [IDX_W-1:0] i);
    ee_addr_of = i[EE_AW-1:0];
  endfunction

  // Read path
  always_comb begin
    rd_word = flash_mem[flash_addr];
    rd_byte = 8'h00;
    case (cmd)
      CMD_RD_FLASH: rd_byte = pins.half ? rd_word[15:8] : rd_word[7:0];
      CMD_RD_EE: rd_byte = ee_mem[ee_addr];
      CMD_RD_SIG: begin
        if (pins.half) begin
          rd_byte = CAL_BYTE;
        end else begin
          case (addr_lo)
            8'h00: rd_byte = SIG_BYTE0;
            8'h01: rd_byte = SIG_BYTE1;
            8'h02: rd_byte = SIG_BYTE2;
            default: rd_byte = 8'h00;
          endcase
        end
      end
      CMD_RD_FUSE: begin
        case ({pins.ext, pins.half})
          2'h0: rd_byte = fuse_low;
          2'h3: rd_byte = fuse_high;
          2'h2: rd_byte = fuse_ext;
          default: rd_byte = lock;
        endcase
      end
      default: rd_byte = 8'h00;
    endcase
    next_data_out = rd_byte;
    next_oe_n = ~(prog_mode_active & ~pins.oe_n);
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      idx <= '0;
      cmd <= CMD_RESET;
      addr_lo <= 8'h00;
      addr_hi <= 8'h00;
      data_lo <= 8'h00;
      fuse_low <= FUSE_LOW_RESET;
      fuse_high <= FUSE_HIGH_RESET;
      fuse_ext <= FUSE_EXT_RESET;
      lock <= LOCK_RESET;
      settle <= 2'h0;
      prog_mode_active <= 1'b0;
      prog_ready_flag <= 1'b1;
      ev_seen <= 1'b0;
      wr_prev <= 1'b1;
      data_out <= 8'h00;
      data_oe_n <= 1'b1;
    end else begin
      state <= next_state;
      idx <= next_idx;
      cmd <= next_cmd;
      addr_lo <= next_addr_lo;
      addr_hi <= next_addr_hi;
      data_lo <= next_data_lo;
      fuse_low <= next_fuse_low;
      fuse_high <= next_fuse_high;
      fuse_ext <= next_fuse_ext;
      lock <= next_lock;
      settle <= next_settle;
      prog_mode_active <= next_mode;
      prog_ready_flag <= next_ready;
      ev_seen <= ev_toggle_s;
      wr_prev <= pins.wr_n;
      data_out <= next_data_out;
      data_oe_n <= next_oe_n;
    end
  end

  // Arrays carry no reset; contents survive like the real memory
  always_ff @(posedge clk_sys) begin
    if (flash_we) flash_mem[flash_wa] <= flash_wd;
    if (ee_we) ee_mem[ee_wa] <= ee_wd;
    if (pbuf_we) pbuf[addr_lo[PAGE_AW-1:0]] <= {ev.data, data_lo};
    if (eebuf_we) eebuf[addr_lo[EE_PAGE_AW-1:0]] <= ev.data;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  busy_flag_low_a: assert property ((state != ST_IDLE) |-> !prog_ready_flag)
    else $error("ready flag high during operation");
  drive_when_read_a: assert property (!data_oe_n |-> prog_mode_active && !$past(pins.oe_n))
    else $error("data bus driven without read enable");
  erase_start_a: assert property (wr_go && cmd == CMD_ERASE |=> state == ST_ERASE_FLASH ##0 !prog_ready_flag)
    else $error("erase did not start on write strobe");
  page_start_a: assert property (wr_go && cmd == CMD_WR_FLASH |=> state == ST_PROG_FLASH)
    else $error("page program did not start");
  cmd_hold_a: assert property (!prog_ready_flag |=> $stable(cmd))
    else $error("command changed while busy");
  lock_after_flash_a: assert property (state == ST_ERASE_LOCK |-> $past(state) inside {ST_ERASE_FLASH, ST_ERASE_EE})
    else $error("lock cleared before memory erase");
  fuse_untouched_a: assert property (state inside {ST_ERASE_FLASH, ST_ERASE_EE, ST_ERASE_LOCK} |=> $stable(fuse_high))
    else $error("erase altered fuses");
  cmd_load_a: assert property (ev_fire && prog_mode_active && prog_ready_flag && ev.action == ACT_CMD
    |=> cmd == $past(ev.data))
    else $error("command byte not loaded");
  ee_page_len_a: assert property (wr_go && cmd == CMD_WR_EE |=> state == ST_PROG_EE [*4] ##1 state == ST_IDLE)
    else $error("eeprom page program length wrong");

  erase_seen_c: cover property (state == ST_ERASE_LOCK);
  flash_page_c: cover property (state == ST_PROG_FLASH ##1 state == ST_IDLE);
  read_drive_c: cover property (!data_oe_n && cmd == CMD_RD_FLASH);
endmodule // parallel_program_port
`default_nettype wire

/* File: prog_model.sv */
// Behavioural external programmer that drives the parallel programming pins.
// Assumes the bench clock; the strobe clock moves only inside a load.
`timescale 1ns/1ns
`default_nettype none
module prog_model (
  // Bench clock and port status
  input wire logic clk_sys,
  input wire logic prog_ready_flag,
  // Programming pins
  output var logic load_strobe_clock,
  output var logic load_action_sel0,
  output var logic load_action_sel1,
  output var logic byte_half_select,
  output var logic byte_extended_select,
  output var logic write_strobe_n,
  output var logic read_enable_n,
  output var logic [7:0] bus_drive
);
  initial begin
    load_strobe_clock = 1'b0;
    {load_action_sel1, load_action_sel0} = 2'h3;
    byte_half_select = 1'b0;
    byte_extended_select = 1'b0;
    write_strobe_n = 1'b1;
    read_enable_n = 1'b1;
    bus_drive = 8'h00;
  end
  // Pattern order: sel1, sel0, half select, write strobe
  task automatic pins(input logic [3:0] pat);
    @(posedge clk_sys);
    {load_action_sel1, load_action_sel0, byte_half_select, write_strobe_n} <= pat;
  endtask
  // 160 ns slot, rise off the system clock phase
  task automatic load(input logic [1:0] act, input logic half, input logic [7:0] val);
    @(posedge clk_sys);
    {load_action_sel1, load_action_sel0} <= act;
    byte_half_select <= half;
    bus_drive <= val;
    #33 load_strobe_clock = 1'b1;
    #80 load_strobe_clock = 1'b0;
    #47;
  endtask
  // Pulse of 26 cycles, then waits for ready before the next request
  task automatic wr_pulse(input logic half, input logic ext, output int busy);
    busy = 0;
    @(posedge clk_sys);
    byte_half_select <= half;
    byte_extended_select <= ext;
    write_strobe_n <= 1'b0;
    for (int n = 0; n < 3000; n++) begin
      @(posedge clk_sys);
      if (n == 25) write_strobe_n <= 1'b1;
      #1;
      if (prog_ready_flag !== 1'b1) busy++;
      else if (busy > 0 && n > 25) break;
    end
  endtask
  // Bus let go while the port may drive it; inverted so a stale value cannot pass
  task automatic rd(input logic half, input logic ext);
    @(posedge clk_sys);
    read_enable_n <= 1'b0;
    byte_half_select <= half;
    byte_extended_select <= ext;
    bus_drive <= ~bus_drive;
    repeat (26) @(posedge clk_sys);
    #1;
  endtask
  task automatic rd_end();
    @(posedge clk_sys);
    read_enable_n <= 1'b1;
    repeat (5) @(posedge clk_sys);
    #1;
  endtask
endmodule // prog_model
`default_nettype wire

/* File: parallel_program_port_tb.sv */
// Self-checking bench: the port against an integer model of its memories.
// Assumes prog_model drives the pins; the bench resolves the shared data bus.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module parallel_program_port_tb
  import prog_port_pkg::*;
;
  logic clk_sys, reset_n, strobe, sel0, sel1, half, ext, wr_n, oe_n, data_oe_n, ready, mode;
  logic [7:0] bus_drive, data_in, data_out;
  logic [7:0] sig [3] = '{SIG_BYTE0, SIG_BYTE1, SIG_BYTE2};
  int flash [1024];
  int ee [128];
  int nv [4];
  int seed, errors, n_checks, busy;
  assign data_in = (data_oe_n === 1'b0) ? data_out : bus_drive;
  parallel_program_port i_dut (.clk_sys(clk_sys), .reset_n(reset_n), .load_strobe_clock(strobe),
    .load_action_sel0(sel0), .load_action_sel1(sel1), .byte_half_select(half), .byte_extended_select(ext),
    .write_strobe_n(wr_n), .read_enable_n(oe_n), .data_in(data_in), .data_out(data_out),
    .data_oe_n(data_oe_n), .prog_ready_flag(ready), .prog_mode_active(mode));
  prog_model i_prog (.clk_sys(clk_sys), .prog_ready_flag(ready), .load_strobe_clock(strobe),
    .load_action_sel0(sel0), .load_action_sel1(sel1), .byte_half_select(half), .byte_extended_select(ext),
    .write_strobe_n(wr_n), .read_enable_n(oe_n), .bus_drive(bus_drive));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    // About 36k cycles are expected; the limit keeps a hang under 100k cycles
    #900_000;
    errors++;
    $display("[ERR] watchdog exp done got hang");
    final_report();
  end
  task automatic rd_chk(input string nm, input logic h, input logic x, input int e);
    i_prog.rd(h, x);
    `CHK("data_oe_n low", 1'b0, data_oe_n)
    `CHK(nm, 8'(e), data_out)
    i_prog.rd_end();
    `CHK("data_oe_n high", 1'b1, data_oe_n)
  endtask
  task automatic wr_chk(input string nm, input logic h, input logic x, input int e);
    i_prog.wr_pulse(h, x, busy);
    `CHK(nm, e, busy)
  endtask
  // Read map: 00 low fuse, 11 high fuse, 10 extended fuse, 01 lock
  task automatic rd_nv();
    i_prog.load(ACT_CMD, 1'b0, CMD_RD_FUSE);
    for (int j = 0; j < 4; j++) rd_chk("fuse or lock", j[0], j[1], nv[j[1] ? (j[0] ? 1 : 2) : (j[0] ? 3 : 0)]);
  endtask
  task automatic ee_rd();
    i_prog.load(ACT_CMD, 1'b0, CMD_RD_EE);
    i_prog.load(ACT_ADDR, 1'b1, 8'h00);
    for (int j = 4; j < 9; j++) begin
      i_prog.load(ACT_ADDR, 1'b0, 8'(j));
      rd_chk("eeprom", 1'b0, 1'b0, ee[j]);
    end
  endtask
  // Erase runs one cycle per word, EEPROM skipped when the preserve fuse is programmed
  task automatic erase_chk();
    i_prog.load(ACT_CMD, 1'b0, CMD_ERASE);
    wr_chk("erase busy", 1'b0, 1'b0, (1 << FLASH_AW_DEF) + (nv[1][EE_PRESERVE_BIT] ? 1 << EE_AW_DEF : 0) + 1);
    for (int j = 0; j < 1024; j++) flash[j] = 'hFFFF;
    for (int j = 0; j < 128 && nv[1][EE_PRESERVE_BIT]; j++) ee[j] = 'hFF;
    nv[3] = 'hFF;
  endtask
  initial begin
    int i, v;
    seed = 34987;
    errors = 0;
    n_checks = 0;
    nv = '{FUSE_LOW_RESET, FUSE_HIGH_RESET, FUSE_EXT_RESET, LOCK_RESET};
    reset_n = 1'b0;
    repeat (5) @(posedge clk_sys);
    repeat (3) i_prog.load(ACT_IDLE, 1'b0, 8'h00);
    i_prog.pins(4'h0);
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (8) @(posedge clk_sys);
    #1;
    `CHK("mode", 1'b1, mode)
    `CHK("ready", 1'b1, ready)
    `CHK("data_oe_n", 1'b1, data_oe_n)
    i_prog.pins(4'hD);
    repeat (3) i_prog.load(ACT_IDLE, 1'b0, 8'h00);
    repeat (30000) @(posedge clk_sys);
    i_prog.load(ACT_CMD, 1'b0, CMD_RD_SIG);
    for (i = 0; i < 3; i++) begin
      i_prog.load(ACT_ADDR, 1'b0, 8'(i));
      rd_chk("signature", 1'b0, 1'b0, sig[i]);
    end
    i_prog.load(ACT_ADDR, 1'b0, 8'h00);
    rd_chk("calibration", 1'b1, 1'b0, CAL_BYTE);
    rd_nv();
    // A command loaded while busy must be dropped, leaving erase as the command
    fork
      erase_chk();
      begin
        repeat (60) @(posedge clk_sys);
        i_prog.load(ACT_CMD, 1'b0, CMD_RD_SIG);
      end
    join
    rd_chk("dropped load", 1'b0, 1'b0, 0);
    i_prog.load(ACT_CMD, 1'b0, CMD_WR_FLASH);
    for (i = 0; i < 16; i++) begin
      v = $random(seed) & 'hFFFF;
      flash[288 + i] = v;
      i_prog.load(ACT_ADDR, 1'b0, 8'(32 + i));
      i_prog.load(ACT_DATA, 1'b0, 8'(v));
      i_prog.load(ACT_DATA, 1'b1, 8'(v >> 8));
    end
    i_prog.load(ACT_ADDR, 1'b1, 8'h01);
    wr_chk("flash busy", 1'b0, 1'b0, 1 << PAGE_AW_DEF);
    i_prog.load(ACT_CMD, 1'b0, CMD_RD_FLASH);
    for (i = 0; i < 17; i++) begin
      i_prog.load(ACT_ADDR, 1'b0, 8'(32 + i));
      rd_chk("flash low", 1'b0, 1'b0, flash[288 + i] & 'hFF);
      rd_chk("flash high", 1'b1, 1'b0, flash[288 + i] >> 8);
    end
    i_prog.load(ACT_CMD, 1'b0, CMD_WR_EE);
    i_prog.load(ACT_ADDR, 1'b1, 8'h00);
    for (i = 4; i < 8; i++) begin
      ee[i] = $random(seed) & 'hFF;
      i_prog.load(ACT_ADDR, 1'b0, 8'(i));
      i_prog.load(ACT_DATA, 1'b0, 8'(ee[i]));
    end
    wr_chk("eeprom busy", 1'b0, 1'b0, 1 << EE_PAGE_AW_DEF);
    ee_rd();
    // High fuse gets bit 6 cleared so the next erase keeps the EEPROM
    for (i = 0; i < 4; i++) begin
      v = $random(seed) & (i == 1 ? 'hBF : 'hFF);
      i_prog.load(ACT_CMD, 1'b0, i == 3 ? CMD_WR_LOCK : CMD_WR_FUSE);
      i_prog.load(ACT_DATA, 1'b0, 8'(v));
      nv[i] = (i == 3) ? (nv[3] & v) : v;
      wr_chk("fuse busy", i == 1, i == 2, 1);
    end
    rd_nv();
    erase_chk();
    rd_nv();
    ee_rd();
    i_prog.load(ACT_CMD, 1'b0, CMD_RD_FLASH);
    i_prog.load(ACT_ADDR, 1'b1, 8'h01);
    i_prog.load(ACT_ADDR, 1'b0, 8'h20);
    rd_chk("erased flash", 1'b0, 1'b0, 'hFF);
    @(posedge clk_sys);
    reset_n <= 1'b0;
    i_prog.pins(4'h4);
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (8) @(posedge clk_sys);
    #1;
    `CHK("mode after reset", 1'b0, mode)
    final_report();
  end
endmodule // parallel_program_port_tb
`default_nettype wire
